// ### hdl/mmp_pkg.sv
// Package for the memory map page register bank: offsets, fields, resets, carriers.
// Assumes a 32-bit AXI4-Lite register bus; byte address is four times the register index.
package mmp_pkg;

    // Register indices; byte address is index times four.
    localparam logic [7:0] MMP_IDX_MODE = 8'h0B;
    localparam logic [7:0] MMP_IDX_GLOBAL = 8'h10;
    localparam logic [7:0] MMP_IDX_DIRECT = 8'h11;
    localparam logic [7:0] MMP_IDX_VIS = 8'h13;
    localparam logic [7:0] MMP_IDX_PROG = 8'h15;
    // Status register of our own: secured, mode lock, direct written flags.
    localparam logic [7:0] MMP_IDX_STATUS = 8'h20;
    localparam int MMP_ADDR_W = 12;

    // Field positions.
    localparam int MMP_MODE_BIT = 7;
    localparam int MMP_SCRATCH_BIT = 7;
    localparam int MMP_DFIFR_BIT = 5;
    localparam int MMP_PFIFR_BIT = 4;
    localparam int MMP_GLOBAL_PAGE_INDEX_W = 7;

    // Mode encoding: 1 normal single-chip, 0 special single-chip.
    localparam logic MMP_MODE_NORMAL = 1'b1;
    localparam logic MMP_MODE_SPECIAL = 1'b0;

    // Reset values.
    localparam logic [7:0] MMP_PROG_RESET = 8'hFE;
    localparam logic [7:0] MMP_PROG_FIXED = 8'hFF;
    localparam logic [7:0] MMP_DIRECT_RESET = 8'h00;
    localparam logic [6:0] MMP_GLOBAL_PAGE_INDEX_RESET = 7'h00;
    localparam logic [7:0] MMP_VIS_RESET = 8'h00;

    // Local map window bounds and program info row base in the global map.
    localparam logic [1:0] MMP_WIN_PAGED = 2'b10;
    localparam logic [1:0] MMP_WIN_FIXED = 2'b11;
    localparam logic [1:0] MMP_WIN_LOW = 2'b01;
    localparam logic [22:0] MMP_PFIFR_BASE = 23'h40_0000;
    localparam logic [22:0] MMP_PFIFR_LAST = 23'h40_3FFF;

    // AXI response codes.
    localparam logic [1:0] MMP_RESP_OKAY = 2'b00;
    localparam logic [1:0] MMP_RESP_SLVERR = 2'b10;

    // Access request from a bus master for translation.
    typedef struct packed {
        logic [15:0] local_addr;
        logic global_instr;
        logic direct_mode;
    } mmp_access_t;

    // Special page access from far call and return instructions.
    typedef struct packed {
        logic wr;
        logic [7:0] page;
    } mmp_far_t;

    // Register write strobe carried to the register core.
    typedef struct packed {
        logic en;
        logic [7:0] idx;
        logic [7:0] data;
    } mmp_wr_t;

endpackage

// ### hdl/mmp_sync.sv
// Two-flop synchroniser for a level from outside the clock domain.
// Assumes the input is a slow level such as a strap pin.
`timescale 1ns/10ps
module mmp_sync (
    input wire logic clock_in,
    input wire logic rst_in,
    input wire logic ce_in,
    input wire logic async_in,
    output logic sync_out
);
    logic meta_q;
    logic sync_q;

    // The first stage feeds only the second stage.
    always_ff @(posedge clock_in)
    begin
        if (rst_in)
        begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
        end
        else if (ce_in)
        begin
            meta_q <= async_in;
            sync_q <= meta_q;
        end
    end

    assign sync_out = sync_q;
endmodule // mmp_sync

// ### hdl/mmp_axil.sv
// AXI4-Lite slave front end producing a one-cycle write strobe and a read index.
// Assumes one outstanding write and one outstanding read; takes AW and W in either order.
`timescale 1ns/10ps
module mmp_axil #(
    parameter int ADDR_W = mmp_pkg::MMP_ADDR_W
) (
    input wire logic clock_in,
    input wire logic rst_in,
    input wire logic ce_in,
    input wire logic [ADDR_W-1:0] awaddr_in,
    input wire logic awvalid_in,
    output logic awready_out,
    input wire logic [31:0] wdata_in,
    input wire logic [3:0] wstrb_in,
    input wire logic wvalid_in,
    output logic wready_out,
    output logic [1:0] bresp_out,
    output logic bvalid_out,
    input wire logic bready_in,
    input wire logic [ADDR_W-1:0] araddr_in,
    input wire logic arvalid_in,
    output logic arready_out,
    output logic [31:0] rdata_out,
    output logic [1:0] rresp_out,
    output logic rvalid_out,
    input wire logic rready_in,
    output mmp_pkg::mmp_wr_t wr_out,
    input wire logic wr_ok_in,
    output logic [7:0] rd_idx_out,
    output logic rd_en_out,
    input wire logic [7:0] rd_data_in,
    input wire logic rd_ok_in
);
    logic aw_have_q;
    logic w_have_q;
    logic [ADDR_W-1:0] awaddr_q;
    logic [7:0] wdata_q;
    logic wlane_q;
    logic bvalid_q;
    logic [1:0] bresp_q;
    logic rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0] rresp_q;
    logic do_write;

    // Index is the word address; bits above the map are ignored.
    function automatic logic [7:0] word_idx(input logic [ADDR_W-1:0] a);
        return a[9:2];
    endfunction

    assign awready_out = !aw_have_q && !bvalid_q;
    assign wready_out = !w_have_q && !bvalid_q;
    assign arready_out = !rvalid_q;
    assign do_write = aw_have_q && w_have_q && !bvalid_q && ce_in;

    // Capture address and data independently.
    always_ff @(posedge clock_in)
    begin
        if (rst_in)
        begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            awaddr_q <= '0;
            wdata_q <= 8'h00;
            wlane_q <= 1'b0;
        end
        else if (ce_in)
        begin
            if (awvalid_in && awready_out)
            begin
                aw_have_q <= 1'b1;
                awaddr_q <= awaddr_in;
            end
            else if (do_write)
                aw_have_q <= 1'b0;
            if (wvalid_in && wready_out)
            begin
                w_have_q <= 1'b1;
                wdata_q <= wdata_in[7:0];
                wlane_q <= wstrb_in[0];
            end
            else if (do_write)
                w_have_q <= 1'b0;
        end
    end

    // Write strobe only when the low byte lane is enabled.
    assign wr_out.en = do_write && wlane_q;
    assign wr_out.idx = word_idx(awaddr_q);
    assign wr_out.data = wdata_q;

    // Write response, SLVERR for unmapped indices.
    always_ff @(posedge clock_in)
    begin
        if (rst_in)
        begin
            bvalid_q <= 1'b0;
            bresp_q <= mmp_pkg::MMP_RESP_OKAY;
        end
        else if (ce_in)
        begin
            if (do_write)
            begin
                bvalid_q <= 1'b1;
                bresp_q <= wr_ok_in ? mmp_pkg::MMP_RESP_OKAY : mmp_pkg::MMP_RESP_SLVERR;
            end
            else if (bready_in)
                bvalid_q <= 1'b0;
        end
    end

    assign rd_idx_out = word_idx(araddr_in);
    assign rd_en_out = arvalid_in && arready_out && ce_in;

    // Read data registered one cycle after the address is taken.
    always_ff @(posedge clock_in)
    begin
        if (rst_in)
        begin
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
            rresp_q <= mmp_pkg::MMP_RESP_OKAY;
        end
        else if (ce_in)
        begin
            if (rd_en_out)
            begin
                rvalid_q <= 1'b1;
                rdata_q <= {24'h00_0000, rd_data_in};
                rresp_q <= rd_ok_in ? mmp_pkg::MMP_RESP_OKAY : mmp_pkg::MMP_RESP_SLVERR;
            end
            else if (rready_in)
                rvalid_q <= 1'b0;
        end
    end

    assign bvalid_out = bvalid_q;
    assign bresp_out = bresp_q;
    assign rvalid_out = rvalid_q;
    assign rdata_out = rdata_q;
    assign rresp_out = rresp_q;
endmodule // mmp_axil

// ### hdl/mmp_page_regs.sv
// Memory map page register bank with local to global address expansion.
// Assumes a synchronous reset, one clock, AXI4-Lite software access and a mode strap pin.
//
// Implementation choice: register access over AXI4-Lite.
`timescale 1ns/10ps

// Overview of operation
// [R1] Mode pin latched into mode bit at reset release.
// [R2] Illegal mode write ignored, then locks in normal.
// [R3] Secured device ignores all mode register writes.
// [R4] Global instruction: global page above local address.
// [R5] Global page field is seven bits wide.
// [R6] Direct page: writes anytime special, once normal; a write made in special mode also uses up the one normal-mode write.
// [R7] Direct access takes page as address bits 15:8.
// [R8] Direct global access uses global page bits.
// [R9] Scratch RAM visible bit, writable anytime.
// [R10] Data flash info row visible bit, writable anytime.
// [R11] Program info row maps up to 0x40_3FFF.
// [R12] Program page selects 16KB block at 0x8000.
// [R13] Program page resets to 0xFE.
// [R14] Local 0xC000 to 0xFFFF fixed at page 0xFF.
// [R15] Far call page writes complete within instruction.
// [R16] Mode: normal is 1, only special to normal.
module mmp_page_regs #(
    parameter int ADDR_W = mmp_pkg::MMP_ADDR_W
) (
    input wire logic clock_in,
    input wire logic rst_in,
    input wire logic ce_in,
    input wire logic [ADDR_W-1:0] awaddr_in,
    input wire logic awvalid_in,
    output logic awready_out,
    input wire logic [31:0] wdata_in,
    input wire logic [3:0] wstrb_in,
    input wire logic wvalid_in,
    output logic wready_out,
    output logic [1:0] bresp_out,
    output logic bvalid_out,
    input wire logic bready_in,
    input wire logic [ADDR_W-1:0] araddr_in,
    input wire logic arvalid_in,
    output logic arready_out,
    output logic [31:0] rdata_out,
    output logic [1:0] rresp_out,
    output logic rvalid_out,
    input wire logic rready_in,
    input wire logic mode_pin_in,
    input wire logic secured_in,
    input wire mmp_pkg::mmp_far_t far_in,
    input wire mmp_pkg::mmp_access_t access_in,
    output logic [22:0] global_addr_out,
    output logic pfifr_hit_out,
    output logic mode_select_bit_out,
    output logic scratch_ram_visible_out,
    output logic data_flash_info_row_visible_out,
    output logic program_flash_info_row_visible_out,
    output logic [7:0] program_window_page_out
);
    mmp_pkg::mmp_wr_t wr;
    logic [7:0] rd_idx;
    logic rd_en;
    logic [7:0] rd_data;
    logic rd_ok;
    logic wr_ok;
    logic mode_pin_sync;
    logic secured_sync;

    logic mode_q;
    logic mode_lock_q;
    logic strap_pending_q;
    logic [6:0] global_page_bits_q;
    logic [7:0] direct_page_bits_q;
    logic direct_written_q;
    logic scratch_q;
    logic dfifr_q;
    logic pfifr_q;
    logic [7:0] prog_q;
    logic [22:0] gaddr_q;
    logic pfifr_hit_q;

    // Whether an index names a register of this bank.
    function automatic logic idx_mapped(input logic [7:0] i);
        return (i == mmp_pkg::MMP_IDX_MODE) || (i == mmp_pkg::MMP_IDX_GLOBAL)
            || (i == mmp_pkg::MMP_IDX_DIRECT) || (i == mmp_pkg::MMP_IDX_VIS)
            || (i == mmp_pkg::MMP_IDX_PROG) || (i == mmp_pkg::MMP_IDX_STATUS);
    endfunction

    // Bus front end.
    mmp_axil #(
        .ADDR_W(ADDR_W)
    ) u_axil (
        .clock_in(clock_in),
        .rst_in(rst_in),
        .ce_in(ce_in),
        .awaddr_in(awaddr_in),
        .awvalid_in(awvalid_in),
        .awready_out(awready_out),
        .wdata_in(wdata_in),
        .wstrb_in(wstrb_in),
        .wvalid_in(wvalid_in),
        .wready_out(wready_out),
        .bresp_out(bresp_out),
        .bvalid_out(bvalid_out),
        .bready_in(bready_in),
        .araddr_in(araddr_in),
        .arvalid_in(arvalid_in),
        .arready_out(arready_out),
        .rdata_out(rdata_out),
        .rresp_out(rresp_out),
        .rvalid_out(rvalid_out),
        .rready_in(rready_in),
        .wr_out(wr),
        .wr_ok_in(wr_ok),
        .rd_idx_out(rd_idx),
        .rd_en_out(rd_en),
        .rd_data_in(rd_data),
        .rd_ok_in(rd_ok)
    );

    // Pins from outside the domain pass two flops first.
    mmp_sync u_sync_mode (
        .clock_in(clock_in),
        .rst_in(1'b0),
        .ce_in(ce_in),
        .async_in(mode_pin_in),
        .sync_out(mode_pin_sync)
    );

    mmp_sync u_sync_sec (
        .clock_in(clock_in),
        .rst_in(rst_in),
        .ce_in(ce_in),
        .async_in(secured_in),
        .sync_out(secured_sync)
    );

    assign wr_ok = idx_mapped(wr.idx);
    assign rd_ok = idx_mapped(rd_idx);

    // Mode bit: the strap is sampled on the first enabled edge after reset release,
    // so the reset itself only loads constants. The strap synchroniser has its reset
    // tied low, so it keeps tracking the pin during reset.
    always_ff @(posedge clock_in)
    begin
        if (rst_in)
        begin
            mode_q <= mmp_pkg::MMP_MODE_SPECIAL;
            mode_lock_q <= 1'b0;
            strap_pending_q <= 1'b1;
        end
        else if (ce_in)
        begin
            if (strap_pending_q)
            begin
                mode_q <= mode_pin_sync; // [R1]
                strap_pending_q <= 1'b0;
            end
            else if (wr.en && wr.idx == mmp_pkg::MMP_IDX_MODE && !secured_sync // [R3]
                     && !mode_lock_q)
            begin
                // Only special to normal is allowed; staying put is harmless.
                if (wr.data[mmp_pkg::MMP_MODE_BIT] == mode_q
                    || (mode_q == mmp_pkg::MMP_MODE_SPECIAL
                        && wr.data[mmp_pkg::MMP_MODE_BIT] == mmp_pkg::MMP_MODE_NORMAL)) // [R16]
                    mode_q <= wr.data[mmp_pkg::MMP_MODE_BIT];
                else if (mode_q == mmp_pkg::MMP_MODE_NORMAL)
                    mode_lock_q <= 1'b1; // [R2]
            end
        end
    end

    // Global page register, seven bits, writable anytime.
    always_ff @(posedge clock_in)
    begin
        if (rst_in)
            global_page_bits_q <= mmp_pkg::MMP_GLOBAL_PAGE_INDEX_RESET;
        else if (ce_in && wr.en && wr.idx == mmp_pkg::MMP_IDX_GLOBAL)
            global_page_bits_q <= wr.data[mmp_pkg::MMP_GLOBAL_PAGE_INDEX_W-1:0]; // [R5]
    end

    // Direct page register: outside special mode, written only if not yet written since reset in either mode.
    always_ff @(posedge clock_in)
    begin
        if (rst_in)
        begin
            direct_page_bits_q <= mmp_pkg::MMP_DIRECT_RESET;
            direct_written_q <= 1'b0;
        end
        else if (ce_in && wr.en && wr.idx == mmp_pkg::MMP_IDX_DIRECT)
        begin
            if (mode_q == mmp_pkg::MMP_MODE_SPECIAL || !direct_written_q) // [R6]
                direct_page_bits_q <= wr.data;
            direct_written_q <= 1'b1;
        end
    end

    // Visibility bits, writable anytime.
    always_ff @(posedge clock_in)
    begin
        if (rst_in)
        begin
            scratch_q <= mmp_pkg::MMP_VIS_RESET[mmp_pkg::MMP_SCRATCH_BIT];
            dfifr_q <= mmp_pkg::MMP_VIS_RESET[mmp_pkg::MMP_DFIFR_BIT];
            pfifr_q <= mmp_pkg::MMP_VIS_RESET[mmp_pkg::MMP_PFIFR_BIT];
        end
        else if (ce_in && wr.en && wr.idx == mmp_pkg::MMP_IDX_VIS)
        begin
            scratch_q <= wr.data[mmp_pkg::MMP_SCRATCH_BIT]; // [R9]
            dfifr_q <= wr.data[mmp_pkg::MMP_DFIFR_BIT]; // [R10]
            pfifr_q <= wr.data[mmp_pkg::MMP_PFIFR_BIT]; // [R11]
        end
    end

    // Program page: the far-call path wins over a bus write in the same cycle
    // because the instruction is waiting on it; the update lands at the next edge.
    always_ff @(posedge clock_in)
    begin
        if (rst_in)
            prog_q <= mmp_pkg::MMP_PROG_RESET; // [R13]
        else if (ce_in)
        begin
            if (far_in.wr)
                prog_q <= far_in.page; // [R15]
            else if (wr.en && wr.idx == mmp_pkg::MMP_IDX_PROG)
                prog_q <= wr.data;
        end
    end

    // Register read mux.
    always_comb
    begin
        rd_data = 8'h00;
        unique case (rd_idx)
            mmp_pkg::MMP_IDX_MODE: rd_data = {mode_q, 7'h00};
            mmp_pkg::MMP_IDX_GLOBAL: rd_data = {1'b0, global_page_bits_q};
            mmp_pkg::MMP_IDX_DIRECT: rd_data = direct_page_bits_q;
            mmp_pkg::MMP_IDX_VIS: rd_data = {scratch_q, 1'b0, dfifr_q, pfifr_q, 4'h0};
            mmp_pkg::MMP_IDX_PROG: rd_data = prog_q;
            mmp_pkg::MMP_IDX_STATUS: rd_data = {5'h00, direct_written_q, mode_lock_q,
                                                secured_sync};
            default: rd_data = 8'h00;
        endcase
    end

    // Address expansion, registered: one cycle from request to global address.
    always_ff @(posedge clock_in)
    begin
        if (rst_in)
        begin
            gaddr_q <= 23'h00_0000;
            pfifr_hit_q <= 1'b0;
        end
        else if (ce_in)
        begin
            logic [15:0] la;
            la = access_in.local_addr;
            if (access_in.direct_mode)
                la = {direct_page_bits_q, access_in.local_addr[7:0]}; // [R7]
            if (access_in.global_instr)
                gaddr_q <= {global_page_bits_q, la}; // [R4] [R8]
            else if (la[15:14] == mmp_pkg::MMP_WIN_FIXED)
                gaddr_q <= {1'b1, mmp_pkg::MMP_PROG_FIXED, la[13:0]}; // [R14]
            else if (la[15:14] == mmp_pkg::MMP_WIN_PAGED)
                gaddr_q <= {1'b1, prog_q, la[13:0]}; // [R12]
            else if (la[15:14] == mmp_pkg::MMP_WIN_LOW)
                gaddr_q <= {1'b1, mmp_pkg::MMP_PROG_RESET - 8'h01, la[13:0]};
            else
                gaddr_q <= {7'h00, la};
            pfifr_hit_q <= pfifr_q && access_in.global_instr
                && {global_page_bits_q, la} >= mmp_pkg::MMP_PFIFR_BASE
                && {global_page_bits_q, la} <= mmp_pkg::MMP_PFIFR_LAST; // [R11]
        end
    end

    assign global_addr_out = gaddr_q;
    assign pfifr_hit_out = pfifr_hit_q;
    assign mode_select_bit_out = mode_q;
    assign scratch_ram_visible_out = scratch_q;
    assign data_flash_info_row_visible_out = dfifr_q;
    assign program_flash_info_row_visible_out = pfifr_q;
    assign program_window_page_out = prog_q;
endmodule // mmp_page_regs

// ### verif/mmp_page_regs_props.sv
// Checker for the page register bank: port level assertions and covers.
// Assumes it is bound to mmp_page_regs and sees only that module's ports.
`timescale 1ns/10ps
module mmp_page_regs_props (
    input logic clock_in,
    input logic rst_in,
    input logic arvalid_in,
    input logic arready_out,
    input logic [31:0] rdata_out,
    input logic rvalid_out,
    input logic mode_pin_in,
    input logic secured_in,
    input mmp_pkg::mmp_far_t far_in,
    input mmp_pkg::mmp_access_t access_in,
    input logic [22:0] global_addr_out,
    input logic pfifr_hit_out,
    input logic mode_select_bit_out,
    input logic program_flash_info_row_visible_out,
    input logic [7:0] program_window_page_out
);
    logic [15:0] la;
    logic gi;
    logic dm;

    // Request fields split out so the properties stay short.
    assign {la, gi, dm} = access_in;

    default clocking cb @(posedge clock_in);
    endclocking
    default disable iff (rst_in);

    property p_prog_reset;
        $fell(rst_in) |-> program_window_page_out == 8'hFE;
    endproperty
    a_prog_reset: assert property (p_prog_reset)
        else $error("page reset");
    property p_mode_latch;
        $fell(rst_in) |=> mode_select_bit_out == $past(mode_pin_in, 2);
    endproperty
    a_mode_latch: assert property (p_mode_latch)
        else $error("strap not latched");
    // Four quiet edges of secured let the synchroniser catch up first.
    property p_mode_secured;
        (secured_in && !$past(rst_in)) [*4] |=> $stable(mode_select_bit_out);
    endproperty
    a_mode_secured: assert property (p_mode_secured)
        else $error("mode changed secured");
    property p_mode_oneway;
        mode_select_bit_out |=> mode_select_bit_out;
    endproperty
    a_mode_oneway: assert property (p_mode_oneway)
        else $error("left normal");
    property p_global;
        gi && !dm |=> global_addr_out[15:0] == $past(la);
    endproperty
    a_global: assert property (p_global)
        else $error("global addr");
    property p_direct;
        dm |=> global_addr_out[7:0] == $past(la[7:0]);
    endproperty
    a_direct: assert property (p_direct)
        else $error("direct low byte");
    property p_fixed;
        !gi && !dm && la[15:14] == 2'b11 |=> global_addr_out == {1'b1, 8'hFF, $past(la[13:0])};
    endproperty
    a_fixed: assert property (p_fixed)
        else $error("fixed window");
    property p_paged;
        !gi && !dm && !far_in.wr && la[15:14] == 2'b10
            |=> global_addr_out == {1'b1, $past(program_window_page_out), $past(la[13:0])};
    endproperty
    a_paged: assert property (p_paged)
        else $error("paged window");
    property p_far;
        far_in.wr |=> program_window_page_out == $past(far_in.page);
    endproperty
    a_far: assert property (p_far)
        else $error("far page late");
    property p_pfifr;
        gi |=> pfifr_hit_out == ($past(program_flash_info_row_visible_out)
            && global_addr_out[22:14] == 9'h100);
    endproperty
    a_pfifr: assert property (p_pfifr)
        else $error("info row hit");
    property p_read_lat;
        arvalid_in && arready_out |=> rvalid_out && rdata_out[31:8] == 24'h0;
    endproperty
    a_read_lat: assert property (p_read_lat)
        else $error("read late");

    c_far: cover property (far_in.wr);
    c_hit: cover property (pfifr_hit_out);
    c_mode: cover property ($rose(mode_select_bit_out));
endmodule // mmp_page_regs_props

// ### verif/mmp_cpu_model.sv
// CPU side model: drives translation requests and far call page writes.
// Assumes the bench calls its tasks from one process on the shared clock.
`timescale 1ns/10ps
module mmp_cpu_model (
    input wire logic clock_in,
    output mmp_pkg::mmp_access_t access_out,
    output mmp_pkg::mmp_far_t far_out
);
    // Quiet start: no global or direct cycle and no far call.
    initial
    begin
        access_out = '0;
        far_out = '0;
    end

    // One request per call, changed just after an edge and then held.
    task automatic acc(input logic [15:0] a, input logic g, input logic d);
        @(posedge clock_in);
        access_out <= {a, g, d};
    endtask

    // Page scrambled after the pulse so a stale value cannot pass.
    task automatic far(input logic [7:0] p);
        @(posedge clock_in);
        far_out <= {1'b1, p};
        @(posedge clock_in);
        far_out <= {1'b0, ~p};
    endtask
endmodule // mmp_cpu_model

// ### verif/tb_top.sv
// Testbench for the page register bank: AXI4-Lite tasks and scenario list.
// Assumes the checker and the CPU model are compiled before this file.
`timescale 1ns/10ps
module tb_top;
    logic clock_in = 1'b0;
    logic rst_in = 1'b1;
    logic mode_pin_in = 1'b0;
    logic secured_in = 1'b0;
    logic [11:0] awaddr = 12'h000, araddr = 12'h000;
    logic [31:0] wdata = 32'h0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, hit, mode, scr, dfi, pfi;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic [22:0] gaddr;
    logic [7:0] page;
    mmp_pkg::mmp_far_t far;
    mmp_pkg::mmp_access_t acc;
    int errors = 0;
    int n_checks = 0;

    // Free running 250 MHz clock.
    always #2 clock_in = ~clock_in;

    mmp_cpu_model i_mmp_cpu_model (.clock_in(clock_in), .access_out(acc), .far_out(far));

    mmp_page_regs i_mmp_page_regs (.clock_in(clock_in), .rst_in(rst_in), .ce_in(1'b1),
        .awaddr_in(awaddr), .awvalid_in(awvalid), .awready_out(awready), .wdata_in(wdata),
        .wstrb_in(4'hF), .wvalid_in(wvalid), .wready_out(wready), .bresp_out(bresp),
        .bvalid_out(bvalid), .bready_in(bready), .araddr_in(araddr), .arvalid_in(arvalid),
        .arready_out(arready), .rdata_out(rdata), .rresp_out(rresp), .rvalid_out(rvalid),
        .rready_in(rready), .mode_pin_in(mode_pin_in), .secured_in(secured_in), .far_in(far),
        .access_in(acc), .global_addr_out(gaddr), .pfifr_hit_out(hit),
        .mode_select_bit_out(mode), .scratch_ram_visible_out(scr),
        .data_flash_info_row_visible_out(dfi), .program_flash_info_row_visible_out(pfi),
        .program_window_page_out(page));

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic end_sim();
        if (errors == 0 && n_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // AW and W offered together; each dropped when taken.
    task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] er = 2'b00);
        logic done;
        done = 1'b0;
        @(posedge clock_in);
        awaddr <= a;
        wdata <= {24'h0, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do
        begin
            @(posedge clock_in);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid)
            begin
                chk("bresp", {30'h0, bresp}, {30'h0, er});
                bready <= 1'b0;
                done = 1'b1;
            end
        end while (!done);
    endtask

    task automatic rd(input logic [11:0] a, input logic [7:0] exp, input logic [1:0] er = 2'b00);
        logic done;
        done = 1'b0;
        @(posedge clock_in);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do
        begin
            @(posedge clock_in);
            if (arready) arvalid <= 1'b0;
            if (rvalid)
            begin
                chk("rdata", rdata, {24'h0, exp});
                chk("rresp", {30'h0, rresp}, {30'h0, er});
                rready <= 1'b0;
                done = 1'b1;
            end
        end while (!done);
    endtask

    // Global address shows one cycle after the request.
    task automatic tx(input logic [15:0] a, input logic g, input logic d, input logic [22:0] e);
        i_mmp_cpu_model.acc(a, g, d);
        repeat (2) @(posedge clock_in);
        chk("global_addr", {9'h0, gaddr}, {9'h0, e});
    endtask

    // Four reset edges also settle the strap synchroniser.
    task automatic do_reset(input logic pin);
        mode_pin_in <= pin;
        rst_in <= 1'b1;
        repeat (4) @(posedge clock_in);
        rst_in <= 1'b0;
        repeat (2) @(posedge clock_in);
    endtask

    // Special mode first, then normal mode after a second reset.
    initial
    begin
        do_reset(1'b0);
        chk("mode", {31'h0, mode}, 32'h0);
        chk("page", {24'h0, page}, 32'hFE);
        rd(12'h054, 8'hFE);
        tx(16'hC123, 1'b0, 1'b0, 23'h7F_C123);
        tx(16'h8123, 1'b0, 1'b0, 23'h7F_8123);
        wr(12'h040, 8'hFF);
        rd(12'h040, 8'h7F);
        wr(12'h040, 8'h14);
        tx(16'h5000, 1'b1, 1'b0, 23'h14_5000);
        wr(12'h044, 8'h80);
        wr(12'h044, 8'h81);
        rd(12'h044, 8'h81);
        tx(16'hFF34, 1'b0, 1'b1, 23'h7F_8134);
        tx(16'hFF34, 1'b1, 1'b1, 23'h14_8134);
        i_mmp_cpu_model.far(8'h12);
        @(posedge clock_in);
        chk("page", {24'h0, page}, 32'h12);
        tx(16'h8000, 1'b0, 1'b0, 23'h44_8000);
        wr(12'h054, 8'h3C);
        rd(12'h054, 8'h3C);
        wr(12'h04C, 8'hFF);
        rd(12'h04C, 8'hB0);
        chk("visible", {29'h0, scr, dfi, pfi}, 32'h7);
        wr(12'h040, 8'h40);
        tx(16'h3FFF, 1'b1, 1'b0, 23'h40_3FFF);
        chk("hit", {31'h0, hit}, 32'h1);
        tx(16'h4000, 1'b1, 1'b0, 23'h40_4000);
        chk("hit", {31'h0, hit}, 32'h0);
        wr(12'h04C, 8'h00);
        tx(16'h3FFF, 1'b1, 1'b0, 23'h40_3FFF);
        chk("hit", {31'h0, hit}, 32'h0);
        chk("visible", {29'h0, scr, dfi, pfi}, 32'h0);
        wr(12'h100, 8'h5A, 2'b10);
        rd(12'h100, 8'h00, 2'b10);
        secured_in <= 1'b1;
        repeat (6) @(posedge clock_in);
        wr(12'h02C, 8'h80);
        chk("mode", {31'h0, mode}, 32'h0);
        secured_in <= 1'b0;
        repeat (6) @(posedge clock_in);
        wr(12'h02C, 8'h80);
        chk("mode", {31'h0, mode}, 32'h1);
        wr(12'h044, 8'h55);
        rd(12'h044, 8'h81);
        wr(12'h02C, 8'h00);
        rd(12'h02C, 8'h80);
        rd(12'h080, 8'h06);
        do_reset(1'b1);
        chk("mode", {31'h0, mode}, 32'h1);
        wr(12'h044, 8'h22);
        wr(12'h044, 8'h33);
        rd(12'h044, 8'h22);
        end_sim();
    end

    // Watchdog; the tests need under a thousand cycles.
    initial
    begin
        repeat (5000) @(posedge clock_in);
        errors++;
        end_sim();
    end
endmodule // tb_top

bind mmp_page_regs mmp_page_regs_props u_props (.clock_in(clock_in), .rst_in(rst_in),
    .arvalid_in(arvalid_in), .arready_out(arready_out), .rdata_out(rdata_out),
    .rvalid_out(rvalid_out), .mode_pin_in(mode_pin_in), .secured_in(secured_in),
    .far_in(far_in), .access_in(access_in), .global_addr_out(global_addr_out),
    .pfifr_hit_out(pfifr_hit_out), .mode_select_bit_out(mode_select_bit_out),
    .program_flash_info_row_visible_out(program_flash_info_row_visible_out),
    .program_window_page_out(program_window_page_out));
